// ==== logic/bsba_alu.sv ====
module bsba_alu
    import bsba_pkg::*;
(
    // clock and reset
    input  wire logic   sys_clk,
    input  wire logic   rst,
    // request from the sequencer
    input  wire logic   req_valid,
    input  bsba_req_s   req,
    // answer to write-back
    output logic        ans_valid,
    output bsba_ans_s   ans
);

    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================
    // size helpers
    function automatic logic [5:0] width_of(input bsba_size_e sz);
        case (sz)
            BSBA_SZ_BYTE:  width_of = BSBA_W_BYTE;
            BSBA_SZ_WORD:  width_of = BSBA_W_WORD;
            default:       width_of = BSBA_W_DWORD;
        endcase
    endfunction : width_of

    function automatic logic [BSBA_DATA_W-1:0] mask_of(input bsba_size_e sz);
        case (sz)
            BSBA_SZ_BYTE:  mask_of = 32'h0000_00ff;
            BSBA_SZ_WORD:  mask_of = 32'h0000_ffff;
            default:       mask_of = 32'hffff_ffff;
        endcase
    endfunction : mask_of

    // =====================================================
    // combinational datapath
    logic [BSBA_DATA_W-1:0] msk;
    logic [BSBA_DATA_W-1:0] d;
    logic [BSBA_DATA_W-1:0] s;
    logic                   c;
    logic                   t;
    logic [4:0]             msb;
    logic [4:0]             bit_idx;
    logic [7:0]             al;
    logic [7:0]             ah;
    logic                   found;
    logic                   next_ans_valid;
    bsba_ans_s              next_ans;

    always_comb
    begin
        msk      = mask_of(req.size);
        msb      = 5'(width_of(req.size) - 6'h01);
        d        = req.dst & msk;
        s        = req.src & msk;
        c        = req.carry_flag;
        t        = 1'b0;
        al       = req.dst[7:0];
        ah       = req.dst[15:8];
        found    = 1'b0;
        bit_idx  = req.src[4:0] & msb;
        next_ans = '0;
        next_ans.carry_flag = req.carry_flag;
        case (req.op)
            // decimal ops touch at most the low two bytes (packed ones only the low byte), upper half passes through
            BSBA_PACKED_ADD_FIXUP:
            begin
                c = 1'b0;
                if (al[3:0] > BSBA_DIGIT_MAX || req.aux_carry)
                begin
                    al = al + BSBA_LOW_FIX;
                end
                if (req.dst[7:0] > BSBA_BYTE_MAX || req.carry_flag)
                begin
                    al = al + BSBA_HIGH_FIX;
                    c  = 1'b1;
                end
                d = {req.dst[31:8], al};
                next_ans.carry_we = 1'b1;
            end
            BSBA_PACKED_SUB_FIXUP:
            begin
                c = 1'b0;
                if (al[3:0] > BSBA_DIGIT_MAX || req.aux_carry)
                begin
                    al = al - BSBA_LOW_FIX;
                end
                if (req.dst[7:0] > BSBA_BYTE_MAX || req.carry_flag)
                begin
                    al = al - BSBA_HIGH_FIX;
                    c  = 1'b1;
                end
                d = {req.dst[31:8], al};
                next_ans.carry_we = 1'b1;
            end
            BSBA_UNPACKED_ADD_ADJUST, BSBA_UNPACKED_SUB_ADJUST:
            begin
                c = 1'b0;
                if (al[3:0] > BSBA_DIGIT_MAX || req.aux_carry)
                begin
                    c = 1'b1;
                    if (req.op == BSBA_UNPACKED_ADD_ADJUST)
                    begin
                        al = al + BSBA_LOW_FIX;
                        ah = ah + BSBA_ONE;
                    end
                    else
                    begin
                        al = al - BSBA_LOW_FIX;
                        ah = ah - BSBA_ONE;
                    end
                end
                al = al & BSBA_DIGIT_MSK;
                d  = {req.dst[31:16], ah, al};
                next_ans.carry_we = 1'b1;
            end
            // multiply adjust and divide prepare leave carry alone
            BSBA_UNPACKED_MUL_ADJUST:
            begin
                ah = al / BSBA_RADIX;
                al = al % BSBA_RADIX;
                d  = {req.dst[31:16], ah, al};
            end
            BSBA_UNPACKED_DIV_PREPARE:
            begin
                al = 8'(ah * BSBA_RADIX + al);
                d  = {req.dst[31:16], 8'h00, al};
            end
            BSBA_AND:  d = d & s;
            BSBA_OR:   d = d | s;
            BSBA_XOR:  d = d ^ s;
            BSBA_NOT:  d = ~d & msk;
            BSBA_ARITH_SHIFT_LEFT, BSBA_LOGIC_SHIFT_LEFT, BSBA_ARITH_SHIFT_RIGHT,
            BSBA_LOGIC_SHIFT_RIGHT, BSBA_DOUBLE_SHIFT_LEFT, BSBA_DOUBLE_SHIFT_RIGHT,
            BSBA_ROTATE_LEFT, BSBA_ROTATE_RIGHT, BSBA_ROTATE_CARRY_LEFT,
            BSBA_ROTATE_CARRY_RIGHT:
            begin
                // one single-bit step per count, so carry is the last bit out
                for (int i = 0; i < 31; i++)
                begin
                    if (5'(i) < req.count)
                    begin
                        case (req.op)
                            BSBA_ARITH_SHIFT_LEFT, BSBA_LOGIC_SHIFT_LEFT:
                            begin
                                c = d[msb];
                                d = (d << 1) & msk;
                            end
                            BSBA_LOGIC_SHIFT_RIGHT:
                            begin
                                c = d[0];
                                d = d >> 1;
                            end
                            BSBA_ARITH_SHIFT_RIGHT:
                            begin
                                c = d[0];
                                t = d[msb];
                                d = d >> 1;
                                d[msb] = t;
                            end
                            BSBA_DOUBLE_SHIFT_LEFT:
                            begin
                                c = d[msb];
                                d = ((d << 1) | {31'h0, s[msb]}) & msk;
                                s = (s << 1) & msk;
                            end
                            BSBA_DOUBLE_SHIFT_RIGHT:
                            begin
                                c = d[0];
                                t = s[0];
                                d = d >> 1;
                                d[msb] = t;
                                s = s >> 1;
                            end
                            BSBA_ROTATE_LEFT:
                            begin
                                c = d[msb];
                                d = ((d << 1) | {31'h0, c}) & msk;
                            end
                            BSBA_ROTATE_RIGHT:
                            begin
                                c = d[0];
                                d = d >> 1;
                                d[msb] = c;
                            end
                            BSBA_ROTATE_CARRY_LEFT:
                            begin
                                t = d[msb];
                                d = ((d << 1) | {31'h0, c}) & msk;
                                c = t;
                            end
                            BSBA_ROTATE_CARRY_RIGHT:
                            begin
                                t = d[0];
                                d = d >> 1;
                                d[msb] = c;
                                c = t;
                            end
                            default:
                            begin
                                c = c;
                            end
                        endcase
                    end
                end
                // zero count leaves carry alone
                next_ans.carry_we = (req.count != '0);
            end
            // offset wraps at the operand width
            BSBA_BIT_PROBE, BSBA_BIT_PROBE_SET, BSBA_BIT_PROBE_CLEAR, BSBA_BIT_PROBE_INVERT:
            begin
                c = d[bit_idx];
                case (req.op)
                    BSBA_BIT_PROBE_SET:    d[bit_idx] = 1'b1;
                    BSBA_BIT_PROBE_CLEAR:  d[bit_idx] = 1'b0;
                    BSBA_BIT_PROBE_INVERT: d[bit_idx] = ~d[bit_idx];
                    default:               d[bit_idx] = d[bit_idx];
                endcase
                next_ans.carry_we = 1'b1;
            end
            // zero source keeps the destination masked to the operand size and flags empty
            BSBA_SCAN_LOW_FIRST:
            begin
                for (int i = 31; i >= 0; i--)
                begin
                    if (s[i])
                    begin
                        d     = 32'(i);
                        found = 1'b1;
                    end
                end
                next_ans.scan_empty = ~found;
            end
            BSBA_SCAN_HIGH_FIRST:
            begin
                for (int i = 0; i < 32; i++)
                begin
                    if (s[i])
                    begin
                        d     = 32'(i);
                        found = 1'b1;
                    end
                end
                next_ans.scan_empty = ~found;
            end
            // unused codes pass the destination, carry alone
            default:
            begin
                d = req.dst;
            end
        endcase
        next_ans.result = d;
        if (next_ans.carry_we)
        begin
            next_ans.carry_flag = c;
        end
        // no request gives an all-zero answer
        next_ans_valid = req_valid;
        if (!req_valid)
        begin
            next_ans = '0;
        end
    end

    // =====================================================
    // answer register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            ans_valid <= 1'b0;
            ans       <= '0;
        end
        else
        begin
            ans_valid <= next_ans_valid;
            ans       <= next_ans;
        end
    end

endmodule : bsba_alu

// ==== logic/bsba_pkg.sv ====
package bsba_pkg;
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================
    // widths and decimal constants
    localparam int          BSBA_DATA_W    = 32;
    localparam int          BSBA_CNT_W     = 5;
    localparam logic [3:0]  BSBA_DIGIT_MAX = 4'h9;
    localparam logic [7:0]  BSBA_LOW_FIX   = 8'h06;
    localparam logic [7:0]  BSBA_HIGH_FIX  = 8'h60;
    localparam logic [7:0]  BSBA_BYTE_MAX  = 8'h99;
    localparam logic [7:0]  BSBA_RADIX     = 8'h0a;
    localparam logic [7:0]  BSBA_ONE       = 8'h01;
    localparam logic [7:0]  BSBA_DIGIT_MSK = 8'h0f;
    localparam logic [5:0]  BSBA_W_BYTE    = 6'h08;
    localparam logic [5:0]  BSBA_W_WORD    = 6'h10;
    localparam logic [5:0]  BSBA_W_DWORD   = 6'h20;

    // =====================================================
    // operations and operand sizes
    typedef enum logic [4:0] {
        BSBA_PACKED_ADD_FIXUP,
        BSBA_PACKED_SUB_FIXUP,
        BSBA_UNPACKED_ADD_ADJUST,
        BSBA_UNPACKED_SUB_ADJUST,
        BSBA_UNPACKED_MUL_ADJUST,
        BSBA_UNPACKED_DIV_PREPARE,
        BSBA_AND,
        BSBA_OR,
        BSBA_XOR,
        BSBA_NOT,
        BSBA_ARITH_SHIFT_LEFT,
        BSBA_LOGIC_SHIFT_LEFT,
        BSBA_ARITH_SHIFT_RIGHT,
        BSBA_LOGIC_SHIFT_RIGHT,
        BSBA_DOUBLE_SHIFT_LEFT,
        BSBA_DOUBLE_SHIFT_RIGHT,
        BSBA_ROTATE_LEFT,
        BSBA_ROTATE_RIGHT,
        BSBA_ROTATE_CARRY_LEFT,
        BSBA_ROTATE_CARRY_RIGHT,
        BSBA_BIT_PROBE,
        BSBA_BIT_PROBE_SET,
        BSBA_BIT_PROBE_CLEAR,
        BSBA_BIT_PROBE_INVERT,
        BSBA_SCAN_LOW_FIRST,
        BSBA_SCAN_HIGH_FIRST
    } bsba_op_e;

    typedef enum logic [1:0] {
        BSBA_SZ_BYTE,
        BSBA_SZ_WORD,
        BSBA_SZ_DWORD
    } bsba_size_e;

    // =====================================================
    // request and answer carriers
    typedef struct packed {
        bsba_op_e                 op;
        bsba_size_e               size;
        logic [BSBA_DATA_W-1:0]   dst;
        logic [BSBA_DATA_W-1:0]   src;
        logic [BSBA_CNT_W-1:0]    count;
        logic                     carry_flag;
        logic                     aux_carry;
    } bsba_req_s;

    typedef struct packed {
        logic [BSBA_DATA_W-1:0]   result;
        logic                     carry_flag;
        logic                     carry_we;
        logic                     scan_empty;
    } bsba_ans_s;

endpackage : bsba_pkg

// ==== verif/bsba_alu_sva.sv ====
module bsba_alu_sva
    import bsba_pkg::*;
(
    // clock and reset
    input  wire logic  sys_clk,
    input  wire logic  rst,
    // request and answer
    input  wire logic  req_valid,
    input  bsba_req_s  req,
    input  wire logic  ans_valid,
    input  bsba_ans_s  ans
);
    timeunit 1ns;
    timeprecision 1ns;

    // =====================================================
    // request of the previous edge
    bsba_req_s pr;
    logic      dw;
    always_ff @(posedge sys_clk)
    begin
        pr <= req;
    end
    assign dw = ans_valid && pr.size == BSBA_SZ_DWORD;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    // =====================================================
    // assertions
    sequence s_lone_req;
        req_valid ##1 !req_valid;
    endsequence
    sequence s_one_answer;
        ans_valid ##1 (!ans_valid && ans == '0);
    endsequence
    property p_answer;
        s_lone_req |-> s_one_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle");
    property p_unp_add_carry;
        dw && pr.op == BSBA_UNPACKED_ADD_ADJUST && (pr.dst[3:0] > BSBA_DIGIT_MAX || pr.aux_carry)
            |-> ans.carry_flag && ans.result[15:8] == 8'(pr.dst[15:8] + BSBA_ONE);
    endproperty
    a_unp_add_carry: assert property (p_unp_add_carry) else $error("high byte not raised");
    property p_div_prepare;
        dw && pr.op == BSBA_UNPACKED_DIV_PREPARE |-> ans.result[7:0] == 8'(pr.dst[15:8] * BSBA_RADIX + pr.dst[7:0]);
    endproperty
    a_div_prepare: assert property (p_div_prepare) else $error("divide prepare wrong");
    property p_shift_left;
        dw && pr.op inside {BSBA_ARITH_SHIFT_LEFT, BSBA_LOGIC_SHIFT_LEFT} && pr.count != 5'h00
            |-> ans.result == (pr.dst << pr.count) && ans.carry_flag == pr.dst[6'h20 - pr.count];
    endproperty
    a_shift_left: assert property (p_shift_left) else $error("left shift wrong");
    property p_sar;
        dw && pr.op == BSBA_ARITH_SHIFT_RIGHT && pr.count != 5'h00
            |-> ans.result == 32'($signed(pr.dst) >>> pr.count) && ans.carry_flag == pr.dst[pr.count - 5'h01];
    endproperty
    a_sar: assert property (p_sar) else $error("sign shift wrong");
    property p_rotate;
        dw && pr.op inside {BSBA_ROTATE_LEFT, BSBA_ROTATE_RIGHT} && pr.count != 5'h00
            |-> ans.carry_flag == (pr.op == BSBA_ROTATE_LEFT ? ans.result[0] : ans.result[31]);
    endproperty
    a_rotate: assert property (p_rotate) else $error("rotate carry wrong");
    property p_probe;
        dw && pr.op inside {[BSBA_BIT_PROBE:BSBA_BIT_PROBE_INVERT]} |-> ans.carry_flag == pr.dst[pr.src[4:0]];
    endproperty
    a_probe: assert property (p_probe) else $error("probe carry wrong");
    property p_scan_empty;
        dw && pr.op inside {BSBA_SCAN_LOW_FIRST, BSBA_SCAN_HIGH_FIRST} && pr.src == '0 |-> ans.scan_empty;
    endproperty
    a_scan_empty: assert property (p_scan_empty) else $error("empty scan not flagged");
endmodule : bsba_alu_sva

// ==== verif/bsba_alu_tb.sv ====
module bsba_alu_tb
    import bsba_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    localparam bsba_size_e SZB = BSBA_SZ_BYTE;
    localparam bsba_size_e SZW = BSBA_SZ_WORD;
    localparam bsba_size_e SZD = BSBA_SZ_DWORD;

    typedef struct packed {
        bsba_req_s    rq;
        logic [31:0]  res;
        logic [2:0]   flg;
    } bsba_row_s;

    logic        sys_clk = 1'h0;
    logic        rst = 1'h1;
    logic        req_valid;
    bsba_req_s   req;
    logic        ans_valid;
    bsba_ans_s   ans;
    int          fail_count = 0;
    int          checked = 0;
    int          cycles = 0;

    // request, result, {carry, carry write, scan empty}
    bsba_row_s rows [32] = '{
        '{'{BSBA_PACKED_ADD_FIXUP, SZD, 32'h000000ae, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h00000014, 3'h6},
        '{'{BSBA_PACKED_SUB_FIXUP, SZD, 32'h000000ee, 32'h0, 5'h00, 1'h1, 1'h1}, 32'h00000088, 3'h6},
        '{'{BSBA_UNPACKED_ADD_ADJUST, SZD, 32'h0000010b, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h00000201, 3'h6},
        '{'{BSBA_UNPACKED_SUB_ADJUST, SZD, 32'h000002ff, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h00000109, 3'h6},
        '{'{BSBA_UNPACKED_MUL_ADJUST, SZD, 32'h00000038, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h00000506, 3'h0},
        '{'{BSBA_UNPACKED_DIV_PREPARE, SZD, 32'h00000507, 32'h0, 5'h00, 1'h1, 1'h0}, 32'h00000039, 3'h4},
        '{'{BSBA_AND, SZD, 32'hf0f0f0f0, 32'hff00ff00, 5'h00, 1'h0, 1'h0}, 32'hf000f000, 3'h0},
        '{'{BSBA_OR, SZD, 32'hf0f0f0f0, 32'hff00ff00, 5'h00, 1'h0, 1'h0}, 32'hfff0fff0, 3'h0},
        '{'{BSBA_XOR, SZD, 32'hf0f0f0f0, 32'hff00ff00, 5'h00, 1'h0, 1'h0}, 32'h0ff00ff0, 3'h0},
        '{'{BSBA_NOT, SZD, 32'hf0f0f0f0, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h0f0f0f0f, 3'h0},
        '{'{BSBA_ARITH_SHIFT_LEFT, SZD, 32'h80000001, 32'h0, 5'h01, 1'h0, 1'h0}, 32'h00000002, 3'h6},
        '{'{BSBA_LOGIC_SHIFT_LEFT, SZD, 32'h00000003, 32'h0, 5'h1f, 1'h0, 1'h0}, 32'h80000000, 3'h6},
        '{'{BSBA_LOGIC_SHIFT_RIGHT, SZD, 32'h80000003, 32'h0, 5'h02, 1'h0, 1'h0}, 32'h20000000, 3'h6},
        '{'{BSBA_ARITH_SHIFT_RIGHT, SZD, 32'h80000004, 32'h0, 5'h03, 1'h0, 1'h0}, 32'hf0000000, 3'h6},
        '{'{BSBA_DOUBLE_SHIFT_LEFT, SZD, 32'h12345678, 32'h9abcdef0, 5'h04, 1'h0, 1'h0}, 32'h23456789, 3'h6},
        '{'{BSBA_DOUBLE_SHIFT_LEFT, SZW, 32'h00001234, 32'h00005678, 5'h04, 1'h0, 1'h0}, 32'h00002345, 3'h6},
        '{'{BSBA_DOUBLE_SHIFT_LEFT, SZD, 32'h12345678, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h12345678, 3'h0},
        '{'{BSBA_DOUBLE_SHIFT_RIGHT, SZD, 32'h12345678, 32'h9abcdef1, 5'h04, 1'h0, 1'h0}, 32'h11234567, 3'h6},
        '{'{BSBA_ROTATE_LEFT, SZB, 32'h00000081, 32'h0, 5'h09, 1'h0, 1'h0}, 32'h00000003, 3'h6},
        '{'{BSBA_ROTATE_RIGHT, SZD, 32'h00000001, 32'h0, 5'h01, 1'h0, 1'h0}, 32'h80000000, 3'h6},
        '{'{BSBA_ROTATE_CARRY_LEFT, SZB, 32'h00000080, 32'h0, 5'h02, 1'h0, 1'h0}, 32'h00000001, 3'h2},
        '{'{BSBA_ROTATE_CARRY_RIGHT, SZB, 32'h00000001, 32'h0, 5'h01, 1'h1, 1'h0}, 32'h00000080, 3'h6},
        '{'{BSBA_BIT_PROBE, SZD, 32'h00000010, 32'h4, 5'h00, 1'h0, 1'h0}, 32'h00000010, 3'h6},
        '{'{BSBA_BIT_PROBE_SET, SZD, 32'h0, 32'h1f, 5'h00, 1'h0, 1'h0}, 32'h80000000, 3'h2},
        '{'{BSBA_BIT_PROBE_CLEAR, SZD, 32'hffffffff, 32'h0, 5'h00, 1'h0, 1'h0}, 32'hfffffffe, 3'h6},
        '{'{BSBA_BIT_PROBE_INVERT, SZD, 32'h00000100, 32'h8, 5'h00, 1'h0, 1'h0}, 32'h0, 3'h6},
        '{'{BSBA_SCAN_LOW_FIRST, SZD, 32'h0, 32'h00010100, 5'h00, 1'h0, 1'h0}, 32'h00000008, 3'h0},
        '{'{BSBA_SCAN_HIGH_FIRST, SZD, 32'h0, 32'h00010100, 5'h00, 1'h0, 1'h0}, 32'h00000010, 3'h0},
        '{'{BSBA_SCAN_LOW_FIRST, SZD, 32'h00001234, 32'h0, 5'h00, 1'h1, 1'h0}, 32'h00001234, 3'h5},
        '{'{BSBA_SCAN_HIGH_FIRST, SZD, 32'h00000077, 32'h0, 5'h00, 1'h0, 1'h0}, 32'h00000077, 3'h1},
        '{'{BSBA_ARITH_SHIFT_RIGHT, SZD, 32'h4000000c, 32'h0, 5'h03, 1'h0, 1'h0}, 32'h08000001, 3'h6},
        '{'{bsba_op_e'(5'h1f), SZD, 32'h00000055, 32'h0, 5'h00, 1'h1, 1'h0}, 32'h00000055, 3'h4}
    };

    always
    begin
        #25 sys_clk = ~sys_clk;
    end

    bsba_seq_model u_seq (.sys_clk(sys_clk), .req_valid(req_valid), .req(req));
    bsba_alu u_dut (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req(req), .ans_valid(ans_valid), .ans(ans));

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : chk

    task automatic final_report();
        if (fail_count == 0 && checked > 0)
        begin
            $display("Testbench passed");
        end
        else
        begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 400)
        begin
            fail_count++;
            final_report();
        end
    end

    initial
    begin
        repeat (12) @(posedge sys_clk);
        #1;
        chk("answer in reset", 32'h0, {31'h0, ans_valid});
        @(negedge sys_clk);
        rst = 1'h0;
        // back to back, one row per cycle
        foreach (rows[i])
        begin
            u_seq.drive(rows[i].rq);
            @(posedge sys_clk);
            #1;
            chk("ans_valid", 32'h1, {31'h0, ans_valid});
            chk("result", rows[i].res, ans.result);
            chk("carry write empty", {29'h0, rows[i].flg}, {29'h0, ans.carry_flag, ans.carry_we, ans.scan_empty});
        end
        u_seq.idle();
        @(posedge sys_clk);
        #1;
        chk("idle answer", 32'h0, {31'h0, ans_valid} | ans.result);
        // reset over a pending request, then first request after it
        u_seq.drive(rows[0].rq);
        rst = 1'h1;
        @(posedge sys_clk);
        #1;
        chk("answer under reset", 32'h0, {31'h0, ans_valid} | ans.result);
        @(negedge sys_clk);
        rst = 1'h0;
        @(posedge sys_clk);
        #1;
        chk("after reset", rows[0].res, ans.result);
        u_seq.idle();
        @(negedge sys_clk);
        final_report();
    end
endmodule : bsba_alu_tb

bind bsba_alu bsba_alu_sva u_sva
(
    .sys_clk   (sys_clk),
    .rst       (rst),
    .req_valid (req_valid),
    .req       (req),
    .ans_valid (ans_valid),
    .ans       (ans)
);

// ==== verif/bsba_seq_model.sv ====
module bsba_seq_model
    import bsba_pkg::*;
(
    // clock
    input  wire logic  sys_clk,
    // request to the datapath
    output logic       req_valid,
    output bsba_req_s  req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        req_valid = 1'h0;
        req       = '0;
    end

    // =====================================================
    // one request, held from the falling edge on
    task automatic drive(input bsba_req_s r);
        @(negedge sys_clk);
        if (r.op inside {BSBA_DOUBLE_SHIFT_LEFT, BSBA_DOUBLE_SHIFT_RIGHT} && r.size == BSBA_SZ_WORD)
        begin
            r.src[31:16] = '0;
        end
        req_valid = 1'h1;
        req       = r;
    endtask : drive

    // released lines show the inverse of the last value
    task automatic idle();
        @(negedge sys_clk);
        req_valid = 1'h0;
        req       = bsba_req_s'(~req);
    endtask : idle
endmodule : bsba_seq_model
